//--- rtl/watch_nmi_enable_set_clear.sv
/*
  Memory watch non-maskable interrupt enables with direct, set and clear
  access, a sticky event status and a maskable summary interrupt.
  Assumes a plain register port: one-cycle strobes, never both at once,
  read data in the cycle after the read strobe; events are one-cycle pulses
  synchronous to i_ref_clk.
*/
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "watch_nmi_consts.svh"

// ****************************************************************
// Behaviour
// - A one written to the area 1 read field of the set register enables that event.
// - A one written to an area 2 write or read field of the set register enables it.
// - A one written to an area 3 write or read field of the set register enables it.
// - A one written to a peripheral area 0 field of the set register enables it.
// - A one written to a peripheral area 1 field of the set register enables it.
// - The clear register sits at 0x328 and a one in any field disables that event.
// - The direct register at 0x320 holds the same bits and loads them as written.
// - The set register sits at 0x324 and a one in area 0 write enables that event.
// ****************************************************************

module watch_nmi_enable_set_clear
  import watch_nmi_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [`WNMI_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [31:0] o_rdata,
  // watch events
  input wire logic [`WNMI_NUM_EVENTS-1:0] i_watch_hit,
  // interrupt outputs
  output logic [`WNMI_NUM_EVENTS-1:0] o_nmi_enable,
  output logic o_nmi,
  output logic o_irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg_sel_type sel;
  logic wr_direct;
  logic wr_set;
  logic wr_clear;
  logic wr_status;
  logic wr_mask;
  watch_vec_type wbits;
  watch_vec_type enable_vec;
  watch_vec_type status_vec;
  watch_vec_type irq_mask_q;

  assign wbits = i_wdata[`WNMI_NUM_EVENTS-1:0];

  // ****************************************************************
  // address decode
  // ****************************************************************
  // unmapped offsets fall to sel_none: writes dropped, reads give zero
  always_comb begin
    unique case (i_addr)
      `WNMI_OFS_DIRECT: begin
        sel = sel_direct;
      end
      `WNMI_OFS_SET: begin
        sel = sel_set;
      end
      `WNMI_OFS_CLEAR: begin
        sel = sel_clear;
      end
      `WNMI_OFS_STATUS: begin
        sel = sel_status;
      end
      `WNMI_OFS_IRQ_MASK: begin
        sel = sel_irq_mask;
      end
      default: begin
        sel = sel_none;
      end
    endcase
  end

  assign wr_direct = i_wr_en && (sel == sel_direct);
  assign wr_set = i_wr_en && (sel == sel_set);
  assign wr_clear = i_wr_en && (sel == sel_clear);
  assign wr_status = i_wr_en && (sel == sel_status);
  assign wr_mask = i_wr_en && (sel == sel_irq_mask);

  // ****************************************************************
  // per-event enable and status
  // ****************************************************************
  for (genvar k = 0; k < `WNMI_NUM_EVENTS; k++) begin : g_event
    watch_nmi_cell u_cell (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_direct_we(wr_direct),
      .i_set_we(wr_set),
      .i_clear_we(wr_clear),
      .i_status_we(wr_status),
      .i_wbit(wbits[k]),
      .i_event(i_watch_hit[k]),
      .o_enable(enable_vec[k]),
      .o_status(status_vec[k])
    );
  end

  // ****************************************************************
  // summary interrupt mask
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask_q <= `WNMI_RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask_q <= wbits;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  // data stand for one cycle only, so a stale value never looks like a read
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `WNMI_RST_RDATA;
    end else if (i_rd_en) begin
      unique case (sel)
        sel_direct, sel_set, sel_clear: begin
          o_rdata <= {`WNMI_RD_PAD, enable_vec};
        end
        sel_status: begin
          o_rdata <= {`WNMI_RD_PAD, status_vec};
        end
        sel_irq_mask: begin
          o_rdata <= {`WNMI_RD_PAD, irq_mask_q};
        end
        sel_none: begin
          o_rdata <= `WNMI_RST_RDATA;
        end
      endcase
    end else begin
      o_rdata <= `WNMI_RST_RDATA;
    end
  end

  // ****************************************************************
  // interrupt outputs
  // ****************************************************************
  // the nmi is gated only by the enables; the irq mask never hides it
  assign o_nmi_enable = enable_vec;
  assign o_nmi = |(status_vec & enable_vec);
  assign o_irq = |(status_vec & irq_mask_q);

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb_ref @(posedge i_ref_clk);
  endclocking

  default disable iff (!i_rst_n);

  sequence s_set_wr(int b);
    i_wr_en && (i_addr == `WNMI_OFS_SET) && i_wdata[b];
  endsequence

  sequence s_clr_wr(int b);
    i_wr_en && (i_addr == `WNMI_OFS_CLEAR) && i_wdata[b];
  endsequence

  sequence s_any_wr(logic [`WNMI_ADDR_W-1:0] ofs);
    i_wr_en && (i_addr == ofs);
  endsequence

  sequence s_rd(logic [`WNMI_ADDR_W-1:0] ofs);
    i_rd_en && (i_addr == ofs);
  endsequence

  property p_area1_read_on;
    s_set_wr(`WNMI_BIT_AREA1_RD) |=> enable_vec[`WNMI_BIT_AREA1_RD];
  endproperty
  a_area1_read_on: assert property (p_area1_read_on)
    else $error("area1 read enable not set by set write");

  property p_area2_on;
    (s_set_wr(`WNMI_BIT_AREA2_WR) |=> enable_vec[`WNMI_BIT_AREA2_WR]) and
    (s_set_wr(`WNMI_BIT_AREA2_RD) |=> enable_vec[`WNMI_BIT_AREA2_RD]);
  endproperty
  a_area2_on: assert property (p_area2_on)
    else $error("area2 enable not set by set write");

  property p_area3_on;
    (s_set_wr(`WNMI_BIT_AREA3_WR) |=> enable_vec[`WNMI_BIT_AREA3_WR]) and
    (s_set_wr(`WNMI_BIT_AREA3_RD) |=> enable_vec[`WNMI_BIT_AREA3_RD]);
  endproperty
  a_area3_on: assert property (p_area3_on)
    else $error("area3 enable not set by set write");

  property p_parea0_on;
    (s_set_wr(`WNMI_BIT_PAREA0_WR) |=> enable_vec[`WNMI_BIT_PAREA0_WR]) and
    (s_set_wr(`WNMI_BIT_PAREA0_RD) |=> enable_vec[`WNMI_BIT_PAREA0_RD]);
  endproperty
  a_parea0_on: assert property (p_parea0_on)
    else $error("peripheral area0 enable not set by set write");

  property p_parea1_on;
    (s_set_wr(`WNMI_BIT_PAREA1_WR) |=> enable_vec[`WNMI_BIT_PAREA1_WR]) and
    (s_set_wr(`WNMI_BIT_PAREA1_RD) |=> enable_vec[`WNMI_BIT_PAREA1_RD]);
  endproperty
  a_parea1_on: assert property (p_parea1_on)
    else $error("peripheral area1 enable not set by set write");

  property p_clear_off;
    (s_clr_wr(`WNMI_BIT_AREA0_WR) |=> !enable_vec[`WNMI_BIT_AREA0_WR]) and
    (s_any_wr(`WNMI_OFS_CLEAR) |=> ((enable_vec & $past(wbits)) == 12'h000));
  endproperty
  a_clear_off: assert property (p_clear_off)
    else $error("clear write left an enable on");

  property p_direct_load;
    s_any_wr(`WNMI_OFS_DIRECT) |=> (enable_vec == $past(wbits));
  endproperty
  a_direct_load: assert property (p_direct_load)
    else $error("direct write did not load the enables");

  property p_area0_write_on;
    s_set_wr(`WNMI_BIT_AREA0_WR) ##1 1'b1 |-> enable_vec[`WNMI_BIT_AREA0_WR];
  endproperty
  a_area0_write_on: assert property (p_area0_write_on)
    else $error("area0 write enable not set by set write");

  property p_zero_keeps;
    (s_any_wr(`WNMI_OFS_SET) or s_any_wr(`WNMI_OFS_CLEAR)) |=>
      (((enable_vec ^ $past(enable_vec)) & ~$past(wbits)) == 12'h000);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("zero bit of set or clear changed an enable");

  property p_read_enable;
    (i_rd_en && ((i_addr == `WNMI_OFS_SET) || (i_addr == `WNMI_OFS_CLEAR))) |=>
      (o_rdata == {`WNMI_RD_PAD, $past(enable_vec)});
  endproperty
  a_read_enable: assert property (p_read_enable)
    else $error("read of set or clear did not return the enables");

  property p_rdata_idle;
    !i_rd_en |=> (o_rdata == `WNMI_RST_RDATA);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  property p_event_sticky;
    (|i_watch_hit) |=> ((status_vec & $past(i_watch_hit)) == $past(i_watch_hit));
  endproperty
  a_event_sticky: assert property (p_event_sticky)
    else $error("watch event lost from status");

  property p_nmi_follows;
    (s_any_wr(`WNMI_OFS_DIRECT) ##1 (enable_vec == 12'h000)) |-> !o_nmi;
  endproperty
  a_nmi_follows: assert property (p_nmi_follows)
    else $error("nmi high with every enable off");

  // a hit in the same cycle keeps its bit, so it is excused here
  property p_status_clear;
    s_any_wr(`WNMI_OFS_STATUS) |=>
      ((status_vec & $past(wbits) & ~$past(i_watch_hit)) == 12'h000);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status bit not cleared by a one written to it");

  property p_status_only_by_event;
    (i_watch_hit == 12'h000) |=> ((status_vec & ~$past(status_vec)) == 12'h000);
  endproperty
  a_status_only_by_event: assert property (p_status_only_by_event)
    else $error("status bit set without a watch event");

  property p_status_keeps;
    !(i_wr_en && (i_addr == `WNMI_OFS_STATUS)) |=>
      ((~status_vec & $past(status_vec)) == 12'h000);
  endproperty
  a_status_keeps: assert property (p_status_keeps)
    else $error("status bit dropped without a clear write");

  property p_mask_load;
    s_any_wr(`WNMI_OFS_IRQ_MASK) |=> (irq_mask_q == $past(wbits));
  endproperty
  a_mask_load: assert property (p_mask_load)
    else $error("irq mask write did not load the mask");

  property p_enable_hold;
    !i_wr_en |=> (enable_vec == $past(enable_vec));
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("enable changed without a write");

  property p_unmapped_keeps;
    (i_wr_en && (sel == sel_none)) |=>
      ((enable_vec == $past(enable_vec)) && (irq_mask_q == $past(irq_mask_q)));
  endproperty
  a_unmapped_keeps: assert property (p_unmapped_keeps)
    else $error("write to an unmapped offset changed state");

  property p_read_direct;
    s_rd(`WNMI_OFS_DIRECT) |=> (o_rdata == {`WNMI_RD_PAD, $past(enable_vec)});
  endproperty
  a_read_direct: assert property (p_read_direct)
    else $error("read of direct register did not return the enables");

  property p_read_status;
    s_rd(`WNMI_OFS_STATUS) |=> (o_rdata == {`WNMI_RD_PAD, $past(status_vec)});
  endproperty
  a_read_status: assert property (p_read_status)
    else $error("read of status did not return the status");

  property p_read_mask;
    s_rd(`WNMI_OFS_IRQ_MASK) |=> (o_rdata == {`WNMI_RD_PAD, $past(irq_mask_q)});
  endproperty
  a_read_mask: assert property (p_read_mask)
    else $error("read of irq mask did not return the mask");

  property p_read_unmapped;
    (i_rd_en && (sel == sel_none)) |=> (o_rdata == `WNMI_RST_RDATA);
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("read of an unmapped offset not zero");

  property p_nmi_on;
    ((i_watch_hit & enable_vec) != 12'h000) && !i_wr_en |=> o_nmi;
  endproperty
  a_nmi_on: assert property (p_nmi_on)
    else $error("enabled watch event did not raise the nmi");

  property p_irq_on;
    ((i_watch_hit & irq_mask_q) != 12'h000) && !i_wr_en |=> o_irq;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("unmasked watch event did not raise the irq");

endmodule // watch_nmi_enable_set_clear

`default_nettype wire

//--- rtl/watch_nmi_consts.svh
/*
  Offsets, field positions, reset values and widths of the memory watch
  non-maskable interrupt enable registers.
  Assumes it is included by bare name; guarded against double inclusion.
*/
`ifndef WATCH_NMI_CONSTS_SVH
`define WATCH_NMI_CONSTS_SVH

// ****************************************************************
// bus geometry
// ****************************************************************
`define WNMI_ADDR_W 12
`define WNMI_NUM_EVENTS 12

// ****************************************************************
// register offsets
// ****************************************************************
`define WNMI_OFS_DIRECT 12'h320
`define WNMI_OFS_SET 12'h324
`define WNMI_OFS_CLEAR 12'h328
`define WNMI_OFS_STATUS 12'h330
`define WNMI_OFS_IRQ_MASK 12'h334

// ****************************************************************
// reset values
// ****************************************************************
`define WNMI_RST_ENABLE 12'h000
`define WNMI_RST_STATUS 12'h000
`define WNMI_RST_IRQ_MASK 12'h000
`define WNMI_RST_RDATA 32'h00000000
`define WNMI_RD_PAD 20'h00000

// ****************************************************************
// field positions, shared by every register of the block
// ****************************************************************
`define WNMI_BIT_AREA0_WR 0
`define WNMI_BIT_AREA0_RD 1
`define WNMI_BIT_AREA1_WR 2
`define WNMI_BIT_AREA1_RD 3
`define WNMI_BIT_AREA2_WR 4
`define WNMI_BIT_AREA2_RD 5
`define WNMI_BIT_AREA3_WR 6
`define WNMI_BIT_AREA3_RD 7
`define WNMI_BIT_PAREA0_WR 8
`define WNMI_BIT_PAREA0_RD 9
`define WNMI_BIT_PAREA1_WR 10
`define WNMI_BIT_PAREA1_RD 11

`endif

//--- rtl/watch_nmi_pkg.sv
/*
  Types of the memory watch non-maskable interrupt enable block.
  Assumes watch_nmi_consts.svh is on the include path.
*/
`include "watch_nmi_consts.svh"

package watch_nmi_pkg;

  // one bit per watch event
  typedef logic [`WNMI_NUM_EVENTS-1:0] watch_vec_type;

  // register select, one-hot
  typedef enum logic [5:0] {
    sel_none     = 6'h01,
    sel_direct   = 6'h02,
    sel_set      = 6'h04,
    sel_clear    = 6'h08,
    sel_status   = 6'h10,
    sel_irq_mask = 6'h20
  } reg_sel_type;

endpackage

//--- rtl/watch_nmi_cell.sv
/*
  One watch event: its non-maskable interrupt enable and its sticky status.
  Assumes the strobes are one-cycle pulses, at most one of them at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module watch_nmi_cell (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // write strobes, already decoded
  input wire logic i_direct_we,
  input wire logic i_set_we,
  input wire logic i_clear_we,
  input wire logic i_status_we,
  input wire logic i_wbit,
  // event
  input wire logic i_event,
  // state
  output logic o_enable,
  output logic o_status
);

  // ****************************************************************
  // enable
  // ****************************************************************
  // a zero written to set or clear leaves the enable alone
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_enable <= 1'b0;
    end else if (i_direct_we) begin
      o_enable <= i_wbit;
    end else if (i_set_we && i_wbit) begin
      o_enable <= 1'b1;
    end else if (i_clear_we && i_wbit) begin
      o_enable <= 1'b0;
    end
  end

  // ****************************************************************
  // sticky status
  // ****************************************************************
  // the event wins over a clear in the same cycle so no hit is lost
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_status <= 1'b0;
    end else if (i_event) begin
      o_status <= 1'b1;
    end else if (i_status_we && i_wbit) begin
      o_status <= 1'b0;
    end
  end

endmodule // watch_nmi_cell

`default_nettype wire

//--- testbench/tb.sv
/*
  Self-checking bench for the watch event enable block: register port,
  set, clear and direct access, watch events and both interrupt outputs.
  Assumes the rtl/ sources are compiled first and the header is on the path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "watch_nmi_consts.svh"

module tb;
  import watch_nmi_pkg::*;

  logic clk, rst_n, wr_en, rd_en, nmi, irq;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  watch_vec_type hit, exp_en, nmi_en, bit_k;
  int failures, n_compared;

  watch_nmi_enable_set_clear u_watch_nmi_enable_set_clear (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rdata(rdata), .i_watch_hit(hit),
    .o_nmi_enable(nmi_en), .o_nmi(nmi), .o_irq(irq)
  );

  // ****************************************************************
  // bus tasks and checks
  // ****************************************************************
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // write effect is visible once the task returns
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // read data stand one cycle only, then the port must fall back to zero
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk("read data", exp, rdata);
    @(posedge clk);
    #1;
    chk("read data idle", 32'h00000000, rdata);
  endtask

  task automatic chk_all();
    chk("enable port", {20'h00000, exp_en}, {20'h00000, nmi_en});
    rd_chk(`WNMI_OFS_DIRECT, {20'h00000, exp_en});
    rd_chk(`WNMI_OFS_SET, {20'h00000, exp_en});
    rd_chk(`WNMI_OFS_CLEAR, {20'h00000, exp_en});
  endtask

  // a random byte address that hits none of the mapped registers
  function automatic logic [11:0] spare_addr(input logic [11:0] r);
    return (r >= 12'h320 && r < 12'h338) ? 12'h100 : r;
  endfunction

  // level a gated summary output must show for a given status
  function automatic logic gated(input watch_vec_type st, input watch_vec_type g);
    return |(st & g);
  endfunction

  // ****************************************************************
  // clock, watchdog, main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end

  initial begin
    int op;
    logic [31:0] r;
    watch_vec_type msk;
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 12'h000;
    wdata = 32'h00000000;
    hit = 12'h000;
    exp_en = 12'h000;
    failures = 0;
    n_compared = 0;
    r = $urandom(32'h79485189);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_all();
    rd_chk(`WNMI_OFS_STATUS, 32'h00000000);
    rd_chk(`WNMI_OFS_IRQ_MASK, 32'h00000000);
    // walk a one through set, then through clear; upper data bits are noise in the set walk, zero in the clear walk
    for (int k = 0; k < 12; k++) begin
      bit_k = 12'h001 << k;
      r = $urandom();
      wr(`WNMI_OFS_SET, {r[31:12], bit_k});
      exp_en = exp_en | bit_k;
      chk_all();
      wr(`WNMI_OFS_CLEAR, 32'h00000000);
      chk("enable port", {20'h00000, exp_en}, {20'h00000, nmi_en});
    end
    for (int k = 0; k < 12; k++) begin
      bit_k = 12'h001 << k;
      wr(`WNMI_OFS_CLEAR, {20'h00000, bit_k});
      exp_en = exp_en & ~bit_k;
      chk_all();
      wr(`WNMI_OFS_SET, 32'h00000000);
      chk("enable port", {20'h00000, exp_en}, {20'h00000, nmi_en});
    end
    // random mix of set, clear, direct and unmapped writes
    for (int i = 0; i < 60; i++) begin
      op = $urandom() % 4;
      r = $urandom();
      case (op)
        0: begin
          wr(`WNMI_OFS_SET, r);
          exp_en = exp_en | r[11:0];
        end
        1: begin
          wr(`WNMI_OFS_CLEAR, r);
          exp_en = exp_en & ~r[11:0];
        end
        2: begin
          wr(`WNMI_OFS_DIRECT, r);
          exp_en = r[11:0];
        end
        default: begin
          wr(spare_addr(r[27:16]), r);
          rd_chk(spare_addr(r[27:16]), 32'h00000000);
        end
      endcase
      chk_all();
    end
    // events: only enabled status reaches the nmi, only masked status the irq
    wr(`WNMI_OFS_DIRECT, 32'h00000020);
    exp_en = 12'h020;
    @(posedge clk);
    hit <= 12'h060;
    @(posedge clk);
    hit <= 12'h000;
    #1;
    chk("nmi", 32'h00000001, {31'h0, nmi});
    chk("irq", 32'h00000000, {31'h0, irq});
    rd_chk(`WNMI_OFS_STATUS, 32'h00000060);
    wr(`WNMI_OFS_IRQ_MASK, 32'h00000040);
    chk("irq", 32'h00000001, {31'h0, irq});
    wr(`WNMI_OFS_STATUS, 32'h00000020);
    chk("nmi", 32'h00000000, {31'h0, nmi});
    chk("irq", 32'h00000001, {31'h0, irq});
    wr(`WNMI_OFS_STATUS, 32'h00000040);
    chk("irq", 32'h00000000, {31'h0, irq});
    rd_chk(`WNMI_OFS_STATUS, 32'h00000000);
    chk_all();
    // random events against random enables and mask
    for (int i = 0; i < 20; i++) begin
      r = $urandom();
      exp_en = r[11:0];
      msk = r[23:12];
      wr(`WNMI_OFS_DIRECT, {20'h00000, exp_en});
      wr(`WNMI_OFS_IRQ_MASK, {20'h00000, msk});
      r = $urandom();
      @(posedge clk);
      hit <= r[11:0];
      @(posedge clk);
      hit <= 12'h000;
      #1;
      chk("nmi", {31'h0, gated(r[11:0], exp_en)}, {31'h0, nmi});
      chk("irq", {31'h0, gated(r[11:0], msk)}, {31'h0, irq});
      rd_chk(`WNMI_OFS_STATUS, {20'h00000, r[11:0]});
      wr(`WNMI_OFS_DIRECT, 32'h00000000);
      exp_en = 12'h000;
      chk("nmi", 32'h00000000, {31'h0, nmi});
      wr(`WNMI_OFS_STATUS, 32'h00000FFF);
      rd_chk(`WNMI_OFS_STATUS, 32'h00000000);
    end
    // an event in the cycle of its own status clear wins
    @(posedge clk);
    addr <= `WNMI_OFS_STATUS;
    wdata <= 32'h00000004;
    wr_en <= 1'b1;
    hit <= 12'h004;
    @(posedge clk);
    wr_en <= 1'b0;
    hit <= 12'h000;
    #1;
    rd_chk(`WNMI_OFS_STATUS, 32'h00000004);
    wr(`WNMI_OFS_STATUS, 32'h00000004);
    rd_chk(`WNMI_OFS_STATUS, 32'h00000000);
    chk_all();
    end_sim();
  end
endmodule // tb

`default_nettype wire
